// *** src/mbc_pkg.sv ***
package mbc_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] COMP_CTRL_OFF = 8'h98;
  localparam logic [7:0] LOOP_CTRL_OFF = 8'h9C;
  localparam logic [7:0] RX_DELAY_OFF = 8'hB0;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int CODE_W = 3;
  localparam int VOVR_BIT = 31;
  localparam int VP_LSB = 20;
  localparam int VN_LSB = 16;
  localparam int HOVR_BIT = 15;
  localparam int HP_LSB = 4;
  localparam int HN_LSB = 0;
  localparam int TXDIS_BIT = 15;
  localparam int RX_TAP_LSB = 0;
  localparam int TX_LOCK_BIT = 8;
  localparam int RX_BYP_BIT = 9;
  localparam int RX_TAPS = 8;

  // ----------------------------------------
  // reset values and responses
  // ----------------------------------------
  localparam logic [CODE_W-1:0] COMP_CODE_RST = 3'h4;
  localparam logic [CODE_W-1:0] RX_TAP_RST = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int MCLK_LOW_MHZ = 100;
  localparam int MCLK_HIGH_MHZ = 133;
  localparam int TAP_SLOW_PS = 200;
  localparam int TAP_FAST_PS = 80;
  localparam int RX_SPAN_SLOW_PS = TAP_SLOW_PS * (RX_TAPS - 1);
  localparam int LOCK_TIME_NS = 1000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int COMP_TIME_NS = 640;
  localparam int COMP_CYCLES = (COMP_TIME_NS * CLK_MHZ) / 1000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [CODE_W-1:0] p;
    logic [CODE_W-1:0] n;
  } mbc_codes_s;

  typedef enum logic [1:0] {
    LOOP_OFF = 2'b00,
    LOOP_LOCKING = 2'b01,
    LOOP_LOCKED = 2'b10
  } mbc_loop_e;

endpackage

// *** src/mbc_comp_engine.sv ***
`timescale 1ns/1ps
module mbc_comp_engine import mbc_pkg::*; #(
  parameter int PERIOD = COMP_CYCLES
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic run, // automatic update allowed
  input wire logic sense_p_weak, // pull-up comparator: too weak
  input wire logic sense_n_weak, // pull-down comparator: too weak
  output mbc_codes_s codes // live compensation codes
);

  localparam int CW = $clog2(PERIOD + 1);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (PERIOD < 1) begin : g_chk
    $error("mbc_comp_engine: PERIOD must be at least 1");
  end

  logic [CW-1:0] tick_cnt_q;
  logic tick;

  assign tick = (tick_cnt_q == CW'(PERIOD - 1));

  // update interval; held at zero while not running so a resume starts a full period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
    end else if (ce) begin
      if (!run || tick) begin
        tick_cnt_q <= '0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
      end
    end
  end

  // saturating one-step walk toward the comparator trip point
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      codes <= '{p: COMP_CODE_RST, n: COMP_CODE_RST};
    end else if (ce && run && tick) begin
      if (sense_p_weak && codes.p != '1) begin
        codes.p <= codes.p + 1'b1;
      end else if (!sense_p_weak && codes.p != '0) begin
        codes.p <= codes.p - 1'b1;
      end
      if (sense_n_weak && codes.n != '1) begin
        codes.n <= codes.n + 1'b1;
      end else if (!sense_n_weak && codes.n != '0) begin
        codes.n <= codes.n - 1'b1;
      end
    end
  end

endmodule // mbc_comp_engine

// *** src/mbc_tx_loop.sv ***
`timescale 1ns/1ps
module mbc_tx_loop import mbc_pkg::*; #(
  parameter int LOCK = LOCK_CYCLES
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic loop_disable, // 1 = disable and bypass
  output logic loop_enable, // loop powered and tracking
  output logic loop_bypass, // clock passes undelayed
  output logic loop_locked // early clock valid
);

  localparam int CW = $clog2(LOCK + 1);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (LOCK < 1) begin : g_chk
    $error("mbc_tx_loop: LOCK must be at least 1");
  end

  mbc_loop_e state_q;
  logic [CW-1:0] lock_cnt_q;

  // loop sequencing: reset lands in locking, so the early clock comes up unasked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= LOOP_LOCKING;
      lock_cnt_q <= '0;
    end else if (ce) begin
      unique case (state_q)
        LOOP_OFF: begin
          lock_cnt_q <= '0;
          if (!loop_disable) begin
            state_q <= LOOP_LOCKING;
          end
        end
        LOOP_LOCKING: begin
          if (loop_disable) begin
            state_q <= LOOP_OFF;
          end else if (lock_cnt_q == CW'(LOCK - 1)) begin
            state_q <= LOOP_LOCKED;
          end else begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
          end
        end
        LOOP_LOCKED: begin
          if (loop_disable) begin
            state_q <= LOOP_OFF;
          end
        end
        default: begin
          state_q <= LOOP_OFF;
        end
      endcase
    end
  end

  // registered status toward the clock tree and software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_enable <= 1'b1;
      loop_bypass <= 1'b0;
      loop_locked <= 1'b0;
    end else if (ce) begin
      loop_enable <= !loop_disable;
      loop_bypass <= loop_disable;
      loop_locked <= !loop_disable && (state_q == LOOP_LOCKED);
    end
  end

endmodule // mbc_tx_loop

// *** src/mbc_ctrl.sv ***
`timescale 1ns/1ps
module mbc_ctrl import mbc_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int COMP_PERIOD = COMP_CYCLES,
  parameter int LOCK = LOCK_CYCLES
) (
  input wire logic aclk, // clock, 50 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic [2:0] awprot, // unused protection
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic [2:0] arprot, // unused protection
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic vert_sense_p_weak, // vertical pull-up comparator
  input wire logic vert_sense_n_weak, // vertical pull-down comparator
  input wire logic horiz_sense_p_weak, // horizontal pull-up comparator
  input wire logic horiz_sense_n_weak, // horizontal pull-down comparator
  output mbc_codes_s vert_codes, // codes to vertical buffers
  output mbc_codes_s horiz_codes, // codes to horizontal buffers
  output logic tx_loop_enable, // transmit loop running
  output logic tx_loop_bypass, // transmit loop bypassed
  output logic tx_loop_locked, // early memory clock valid
  output logic rx_loop_bypass, // receive loop bypassed, always 1
  output logic [CODE_W-1:0] rx_tap_sel // receive delay chain tap
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ADDR_W < 8) begin : g_chk_addr
    $error("mbc_ctrl: ADDR_W must cover the register map");
  end
  if (RX_TAPS != (1 << CODE_W)) begin : g_chk_taps
    $error("mbc_ctrl: tap select width does not match tap count");
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  // index 0 is the vertical orientation, index 1 the horizontal one
  logic [1:0] ovr_q;
  mbc_codes_s sw_q [2];
  mbc_codes_s live [2];
  mbc_codes_s shown [2];
  logic [1:0] sense_p;
  logic [1:0] sense_n;
  logic tx_dis_q;
  logic [CODE_W-1:0] rx_tap_q;

  // ----------------------------------------
  // bus state
  // ----------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic wr_fire;
  logic wr_comp;
  logic wr_loop;
  logic wr_rx;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] comp_word;
  logic [31:0] loop_word;
  logic [31:0] rx_word;

  assign sense_p = {horiz_sense_p_weak, vert_sense_p_weak};
  assign sense_n = {horiz_sense_n_weak, vert_sense_n_weak};

  // ----------------------------------------
  // write channels
  // ----------------------------------------
  // address and data are parked independently, so either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready <= 1'b1;
      wr_addr_q <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awready <= 1'b0;
        wr_addr_q <= awaddr;
      end else if (bvalid && bready) begin
        aw_have_q <= 1'b0;
        awready <= 1'b1;
      end
    end
  end

  // write data holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready <= 1'b1;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wready <= 1'b0;
        wr_data_q <= wdata;
        wr_strb_q <= wstrb;
      end else if (bvalid && bready) begin
        w_have_q <= 1'b0;
        wready <= 1'b1;
      end
    end
  end

  // one commit per pair; bvalid blocks a second commit of the same pair
  assign wr_fire = aw_have_q && w_have_q && !bvalid;
  assign wr_comp = wr_fire && (wr_addr_q == ADDR_W'(COMP_CTRL_OFF));
  assign wr_loop = wr_fire && (wr_addr_q == ADDR_W'(LOOP_CTRL_OFF));
  assign wr_rx = wr_fire && (wr_addr_q == ADDR_W'(RX_DELAY_OFF));
  assign wr_hit = wr_comp || wr_loop || wr_rx;

  // write response; unmapped addresses answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // compensation per orientation
  // ----------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_orient
    localparam int OVR = (i == 0) ? VOVR_BIT : HOVR_BIT;
    localparam int PL = (i == 0) ? VP_LSB : HP_LSB;
    localparam int NL = (i == 0) ? VN_LSB : HN_LSB;
    logic code_we;

    // automatic walk only while the override bit is clear
    mbc_comp_engine #(
      .PERIOD(COMP_PERIOD)
    ) u_engine (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .run(!ovr_q[i]),
      .sense_p_weak(sense_p[i]),
      .sense_n_weak(sense_n[i]),
      .codes(live[i])
    );

    // override bit, reset clear so compensation starts at once
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ovr_q[i] <= 1'b0;
      end else if (ce && wr_comp && wr_strb_q[OVR / 8]) begin
        ovr_q[i] <= wr_data_q[OVR];
      end
    end

    // codes accept writes only while override was already set before this write
    assign code_we = wr_comp && ovr_q[i] && wr_strb_q[PL / 8];

    // shadow follows the live value, so entering override keeps the last result
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sw_q[i] <= '{p: COMP_CODE_RST, n: COMP_CODE_RST};
      end else if (ce) begin
        if (!ovr_q[i]) begin
          sw_q[i] <= live[i];
        end else if (code_we) begin
          sw_q[i].p <= wr_data_q[PL +: CODE_W];
          sw_q[i].n <= wr_data_q[NL +: CODE_W];
        end
      end
    end

    // what software reads and what the buffers get
    assign shown[i] = ovr_q[i] ? sw_q[i] : live[i];
  end

  // buffer drive, registered at the top boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vert_codes <= '{p: COMP_CODE_RST, n: COMP_CODE_RST};
      horiz_codes <= '{p: COMP_CODE_RST, n: COMP_CODE_RST};
    end else if (ce) begin
      vert_codes <= shown[0];
      horiz_codes <= shown[1];
    end
  end

  // ----------------------------------------
  // clock loop control
  // ----------------------------------------
  // transmit loop disable bit, reset clear so the early clock runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_dis_q <= 1'b0;
    end else if (ce && wr_loop && wr_strb_q[TXDIS_BIT / 8]) begin
      tx_dis_q <= wr_data_q[TXDIS_BIT];
    end
  end

  // the transmit loop advances the memory clock for write setup margin
  mbc_tx_loop #(
    .LOCK(LOCK)
  ) u_tx_loop (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .loop_disable(tx_dis_q),
    .loop_enable(tx_loop_enable),
    .loop_bypass(tx_loop_bypass),
    .loop_locked(tx_loop_locked)
  );

  // receive tap: each step adds one chain delay, lagging the read clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_tap_q <= RX_TAP_RST;
    end else if (ce && wr_rx && wr_strb_q[RX_TAP_LSB / 8]) begin
      rx_tap_q <= wr_data_q[RX_TAP_LSB +: CODE_W];
    end
  end

  // receive loop never engages; only the tapped chain sets the delay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_loop_bypass <= 1'b1;
      rx_tap_sel <= RX_TAP_RST;
    end else if (ce) begin
      rx_loop_bypass <= 1'b1;
      rx_tap_sel <= rx_tap_q;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // unlisted bit positions stay zero in every word
  always_comb begin
    comp_word = '0;
    comp_word[VOVR_BIT] = ovr_q[0];
    comp_word[VP_LSB +: CODE_W] = shown[0].p;
    comp_word[VN_LSB +: CODE_W] = shown[0].n;
    comp_word[HOVR_BIT] = ovr_q[1];
    comp_word[HP_LSB +: CODE_W] = shown[1].p;
    comp_word[HN_LSB +: CODE_W] = shown[1].n;
    loop_word = '0;
    loop_word[TXDIS_BIT] = tx_dis_q;
    rx_word = '0;
    rx_word[RX_TAP_LSB +: CODE_W] = rx_tap_q;
    rx_word[TX_LOCK_BIT] = tx_loop_locked;
    rx_word[RX_BYP_BIT] = rx_loop_bypass;
  end

  // address decode for reads
  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    if (araddr == ADDR_W'(COMP_CTRL_OFF)) begin
      rd_word = comp_word;
    end else if (araddr == ADDR_W'(LOOP_CTRL_OFF)) begin
      rd_word = loop_word;
    end else if (araddr == ADDR_W'(RX_DELAY_OFF)) begin
      rd_word = rx_word;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read channel: data captured on the address edge, one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // mbc_ctrl

// *** test/mbc_ctrl_asserts.sv ***
`timescale 1ns/1ps
module mbc_ctrl_asserts import mbc_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int COMP_PERIOD = COMP_CYCLES,
  parameter int LOCK = LOCK_CYCLES
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset
  input wire logic ce, // clock enable
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b code
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r code
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic tx_loop_enable, // tx loop on
  input wire logic tx_loop_bypass, // tx loop bypassed
  input wire logic tx_loop_locked, // early clock valid
  input wire logic rx_loop_bypass // rx loop bypassed
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // clock loops
  // ----------------------------------------
  a_rx_always_bypassed: assert property (rx_loop_bypass)
    else $error("receive loop not bypassed");
  a_tx_disable_stops: assert property ($rose(tx_loop_bypass) |-> ##[0:2] (!tx_loop_enable && !tx_loop_locked))
    else $error("transmit loop still running when disabled");
  a_lock_needs_run: assert property ($rose(tx_loop_locked) |-> tx_loop_enable && $past(tx_loop_enable) && !tx_loop_bypass)
    else $error("lock without running loop");
  a_locked_enabled: assert property (tx_loop_locked |-> tx_loop_enable)
    else $error("early clock valid while loop off");

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  // write answer two edges after both halves are taken
  a_wr_resp_time: assert property (awvalid && awready && wvalid && wready && ce |=> !bvalid ##1 bvalid)
    else $error("write response late or early");
  a_wr_one_only: assert property (bvalid |-> !awready && !wready)
    else $error("second write accepted");
  a_b_holds: assert property (bvalid && !(bready && ce) |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rd_resp_time: assert property (arvalid && arready && ce |=> rvalid && !arready)
    else $error("read data not one cycle after address");
  a_r_holds: assert property (rvalid && !(rready && ce) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");

  c_lock: cover property ($rose(tx_loop_locked));
  c_bypass: cover property ($rose(tx_loop_bypass));
  c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule // mbc_ctrl_asserts

bind mbc_ctrl mbc_ctrl_asserts #(.ADDR_W(ADDR_W), .COMP_PERIOD(COMP_PERIOD), .LOCK(LOCK)) i_mbc_ctrl_asserts (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .tx_loop_enable(tx_loop_enable),
  .tx_loop_bypass(tx_loop_bypass), .tx_loop_locked(tx_loop_locked), .rx_loop_bypass(rx_loop_bypass));

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb import mbc_pkg::*;;
  localparam int CP = 8;
  localparam int LK = 3;
  logic aclk, aresetn, ce;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, resv;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, sv, sh;
  mbc_codes_s vert_codes, horiz_codes;
  logic tx_loop_enable, tx_loop_bypass, tx_loop_locked, rx_loop_bypass;
  logic [2:0] rx_tap_sel, tap;
  logic [5:0] cv, ch, ev, eh;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 91;

  mbc_ctrl #(.ADDR_W(12), .COMP_PERIOD(CP), .LOCK(LK)) i_mbc_ctrl (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .vert_sense_p_weak(sv[1]),
    .vert_sense_n_weak(sv[0]), .horiz_sense_p_weak(sh[1]), .horiz_sense_n_weak(sh[0]),
    .vert_codes(vert_codes), .horiz_codes(horiz_codes), .tx_loop_enable(tx_loop_enable),
    .tx_loop_bypass(tx_loop_bypass), .tx_loop_locked(tx_loop_locked), .rx_loop_bypass(rx_loop_bypass),
    .rx_tap_sel(rx_tap_sel));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // saturated live code: sense high climbs to 7, low sinks to 0
  function automatic logic [5:0] live(input logic [1:0] s);
    return {{3{s[1]}}, {3{s[0]}}};
  endfunction

  function automatic logic [31:0] cw(input logic vo, input logic ho, input logic [5:0] v, input logic [5:0] h);
    return {vo, 8'h00, v[5:3], 1'b0, v[2:0], ho, 8'h00, h[5:3], 1'b0, h[2:0]};
  endfunction

  // each channel released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] r = RESP_OKAY);
    bit done;
    exp_b.push_back(r);
    @(posedge aclk);
    awaddr <= {4'h0, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        done = 1;
        bready <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    bit done;
    exp_r.push_back({r, d});
    @(posedge aclk);
    araddr <= {4'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        done = 1;
        rready <= 1'b0;
      end
    end
  endtask

  // results taken off the queues as they appear on the bus
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) check("read", {rresp, rdata}, exp_r.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) check("bresp", 34'(bresp), 34'(exp_b.pop_front()));
  end

  // hang guard, far beyond the well under one thousand cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    stop_test;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready, sv, sh} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(COMP_CTRL_OFF, cw(1'b0, 1'b0, {2{COMP_CODE_RST}}, {2{COMP_CODE_RST}}));
    rd(LOOP_CTRL_OFF, 32'h0000_0000);
    repeat (LK + 4) @(posedge aclk);
    check("tx loop", 34'({tx_loop_enable, tx_loop_bypass, tx_loop_locked}), 34'(3'b101));
    // each override alone, both, and none
    for (int m = 0; m < 4; m++) begin
      sv <= 2'($random(seed));
      sh <= 2'($random(seed));
      repeat (8 * CP) @(posedge aclk);
      rd(COMP_CTRL_OFF, cw(1'b0, 1'b0, live(sv), live(sh)));
      cv = 6'($random(seed));
      ch = 6'($random(seed));
      resv = 32'($random(seed)) & 32'h7F88_7F88;
      wr(COMP_CTRL_OFF, cw(m[0], m[1], ~cv, ~ch) | resv);
      rd(COMP_CTRL_OFF, cw(m[0], m[1], live(sv), live(sh)));
      wr(COMP_CTRL_OFF, cw(m[0], m[1], cv, ch) | resv);
      sv <= ~sv;
      sh <= ~sh;
      repeat (8 * CP) @(posedge aclk);
      ev = m[0] ? cv : live(sv);
      eh = m[1] ? ch : live(sh);
      rd(COMP_CTRL_OFF, cw(m[0], m[1], ev, eh));
      check("vert codes", 34'(vert_codes), 34'(ev));
      check("horiz codes", 34'(horiz_codes), 34'(eh));
      wr(COMP_CTRL_OFF, 32'h0000_0000);
      // before the next tick: an overridden side must still hold its frozen walk result
      rd(COMP_CTRL_OFF, cw(1'b0, 1'b0, m[0] ? live(~sv) : live(sv), m[1] ? live(~sh) : live(sh)));
    end
    wr(LOOP_CTRL_OFF, 32'hFFFF_FFFF, 4'h0);
    rd(LOOP_CTRL_OFF, 32'h0000_0000);
    wr(LOOP_CTRL_OFF, 32'hFFFF_FFFF);
    rd(LOOP_CTRL_OFF, 32'h0000_8000);
    repeat (3) @(posedge aclk);
    check("tx loop", 34'({tx_loop_enable, tx_loop_bypass, tx_loop_locked}), 34'(3'b010));
    wr(LOOP_CTRL_OFF, 32'h0000_0000);
    // clock enable low with the bus idle: relock must not advance
    ce <= 1'b0;
    repeat (LK + 8) @(posedge aclk);
    check("tx frozen", 34'({tx_loop_enable, tx_loop_bypass, tx_loop_locked}), 34'(3'b100));
    ce <= 1'b1;
    repeat (LK + 4) @(posedge aclk);
    check("tx loop", 34'({tx_loop_enable, tx_loop_bypass, tx_loop_locked}), 34'(3'b101));
    tap = 3'($random(seed));
    wr(RX_DELAY_OFF, 32'(tap));
    rd(RX_DELAY_OFF, 32'h0000_0300 | 32'(tap));
    check("tap", 34'(rx_tap_sel), 34'(tap));
    wr(8'hA0, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    rd(8'hA0, 32'h0000_0000, RESP_SLVERR);
    repeat (4) @(posedge aclk);
    stop_test;
  end
endmodule // tb
